// ### hdl/wdt_core.sv
// windowed watchdog timer with prescaler and postscaler
`timescale 1ns/1ps
`include "wdt_map.svh"

// How it works
// - any device reset clears counter and scalers
// - completed clock switch clears counter and scalers
// - power-save entry clears counter and scalers
// - leaving sleep or idle clears counter, scalers
// - clear instruction in run clears counter, scalers
// - config 11 keeps counting in sleep, idle
// - timeout in sleep or idle wakes, no reset
// - timeout flag sticky until software clears it
// - windowed clear works only in final quarter
// - early windowed clear causes watchdog reset
// - window mode when window disable bit is 0
// - config 11 means always enabled
// - config 10 runs only with soft enable
// - device reset clears soft enable bit
// - config 01 runs in run, idle; stops sleep
// - config 01 ignores soft enable bit
module wdt_core #(
  parameter int PRE_DIV  = `WDT_PRE_DIV,
  parameter int POST_DIV = `WDT_POST_DIV
) (
  input  wire logic             I_CLK_SYS,
  input  wire logic             I_NRST,
  input  wire wdt_pkg::wdt_cfg_s I_CFG,
  input  wire wdt_pkg::wdt_evt_s I_EVT,
  input  wire logic             I_SOFT_EN_WR,
  input  wire logic             I_SOFT_EN_VAL,
  input  wire logic             I_FLAG_CLR,
  output logic                  O_SOFT_WATCHDOG_ENABLE,
  output logic                  O_WATCHDOG_TIMEOUT_FLAG,
  output logic                  O_WDT_RESET,
  output logic                  O_WDT_WAKE,
  output logic                  O_SLEEP_STATUS,
  output logic                  O_IDLE_STATUS,
  output logic                  O_WINDOW_OPEN
);
  import wdt_pkg::*;

  localparam int PW = $clog2(PRE_DIV);
  localparam int CW = $clog2(POST_DIV) + 1;
  localparam logic [PW-1:0] PRE_LAST  = PW'(PRE_DIV - 1);
  localparam logic [CW-1:0] POST_LAST = CW'(POST_DIV - 1);
  // window opens for the last quarter of the postscaler span
  localparam logic [CW-1:0] WIN_START = CW'(POST_DIV - POST_DIV / `WDT_WIN_DIV);

  // ************************************************************
  // mode tracking
  // ************************************************************
  wdt_mode_e       mode_q, mode_d;
  logic [PW-1:0]   pre_q;
  logic [CW-1:0]   post_q;
  logic            soft_en_q;
  logic            flag_q;
  logic            rst_q, wake_q;
  logic            slp_st_q, idl_st_q;
  logic            win_q;

  wire in_run   = (mode_q == WDT_RUN);
  wire in_sleep = (mode_q == WDT_SLEEP);
  wire in_idle  = (mode_q == WDT_IDLE);

  function automatic logic wdt_active(input logic [1:0] cfg, input logic sw,
                                      input logic sleeping);
    unique case (cfg)
      `WDT_EN_ALWAYS:  wdt_active = 1'b1;
      `WDT_EN_SOFT:    wdt_active = sw;
      `WDT_EN_RUNIDLE: wdt_active = !sleeping;
      `WDT_EN_OFF:     wdt_active = 1'b0;
    endcase
  endfunction : wdt_active

  wire active      = wdt_active(I_CFG.enable_cfg, soft_en_q, in_sleep);
  wire ps_enter    = I_EVT.power_save_instr && in_run;
  wire ps_exit     = I_EVT.wake_event && !in_run;
  wire win_mode    = !I_CFG.window_mode_disable;
  wire in_window   = post_q >= WIN_START;
  wire clr_run     = I_EVT.watchdog_clear_instr && in_run;
  wire clr_early   = clr_run && win_mode && !in_window && active;
  wire pre_tick    = active && (pre_q == PRE_LAST);
  wire timeout     = pre_tick && (post_q == POST_LAST);
  wire any_timeout = timeout || clr_early;
  // a run timeout restarts the counters one cycle later through rst_q
  wire wdt_wake    = timeout && !in_run;
  wire restart     = I_EVT.osc_switch_done || ps_enter || ps_exit ||
                     wdt_wake || clr_run || !active || rst_q;

  // a wake from the watchdog itself also returns the mode to run
  always_comb begin
    mode_d = mode_q;
    if (ps_enter) begin
      mode_d = I_EVT.power_save_idle ? WDT_IDLE : WDT_SLEEP;
    end else if (ps_exit || wdt_wake) begin
      mode_d = WDT_RUN;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      mode_q <= WDT_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ************************************************************
  // prescaler and postscaler counting
  // ************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pre_q  <= '0;
      post_q <= '0;
    end else if (restart) begin
      pre_q  <= '0;
      post_q <= '0;
    end else begin
      pre_q  <= pre_tick ? '0 : pre_q + PW'(`WDT_CNT_ONE);
      if (pre_tick) begin
        post_q <= post_q + CW'(`WDT_CNT_ONE);
      end
    end
  end

  // ************************************************************
  // software enable and sticky status
  // ************************************************************
  // soft enable is stored even under 01/11; it just has no effect there
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      soft_en_q <= 1'b0;
    end else if (I_SOFT_EN_WR) begin
      soft_en_q <= I_SOFT_EN_VAL;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      flag_q <= 1'b0;
    end else if (any_timeout) begin
      flag_q <= 1'b1;
    end else if (I_FLAG_CLR) begin
      flag_q <= 1'b0;
    end
  end

  // status bits left set after wake; software clears them itself
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      slp_st_q <= 1'b0;
      idl_st_q <= 1'b0;
    end else if (I_FLAG_CLR) begin
      slp_st_q <= 1'b0;
      idl_st_q <= 1'b0;
    end else if (ps_enter) begin
      slp_st_q <= !I_EVT.power_save_idle;
      idl_st_q <= I_EVT.power_save_idle;
    end
  end

  // ************************************************************
  // reset and wake outputs
  // ************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_q  <= 1'b0;
      wake_q <= 1'b0;
      win_q  <= 1'b0;
    end else begin
      rst_q  <= (timeout && in_run) || clr_early;
      wake_q <= wdt_wake;
      win_q  <= active && (!win_mode || in_window);
    end
  end

  assign O_SOFT_WATCHDOG_ENABLE  = soft_en_q;
  assign O_WATCHDOG_TIMEOUT_FLAG = flag_q;
  assign O_WDT_RESET             = rst_q;
  assign O_WDT_WAKE              = wake_q;
  assign O_SLEEP_STATUS          = slp_st_q;
  assign O_IDLE_STATUS           = idl_st_q;
  assign O_WINDOW_OPEN           = win_q;

  // ************************************************************
  // checks
  // ************************************************************
  sequence timeout_run_s;
    timeout && in_run;
  endsequence

  off_holds_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CFG.enable_cfg == `WDT_EN_OFF) |=> (post_q == '0 && pre_q == '0))
    else $error("counter not held in off mode");
  run_timeout_rst_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    timeout_run_s |=> (O_WDT_RESET && O_WATCHDOG_TIMEOUT_FLAG))
    else $error("run timeout did not reset");
  sleep_wake_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (timeout && !in_run) |=> (O_WDT_WAKE && !O_WDT_RESET && in_run))
    else $error("sleep timeout did not wake");
  flag_sticky_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (flag_q && !I_FLAG_CLR) |=> flag_q)
    else $error("timeout flag dropped");
  early_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (clr_run && win_mode && active && post_q < WIN_START) |=> O_WDT_RESET)
    else $error("early clear not punished");
  window_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (clr_run && post_q >= WIN_START && !timeout) |=> (post_q == '0 && !O_WDT_RESET))
    else $error("window clear failed");
  psave_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    ps_enter |=> (pre_q == '0 && post_q == '0))
    else $error("power save did not clear");
  osc_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_EVT.osc_switch_done |=> (pre_q == '0 && post_q == '0))
    else $error("clock switch did not clear");
  sleep_stop_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CFG.enable_cfg == `WDT_EN_RUNIDLE && in_sleep) |=> (post_q == '0))
    else $error("counted in sleep under 01");
  soft_gate_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CFG.enable_cfg == `WDT_EN_SOFT && !soft_en_q) |=> (pre_q == '0))
    else $error("ran without soft enable");

  // ************************************************************
  // span counter for the checks
  // ************************************************************
  // cycles since the last restart; a run period must end by then,
  // otherwise the restart chain after a timeout is broken
  localparam int            SW        = CW + PW;
  localparam logic [SW-1:0] SPAN_LAST = SW'(PRE_DIV * POST_DIV);
  logic [SW-1:0]            span_q;

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      span_q <= '0;
    end else if (restart) begin
      span_q <= '0;
    end else begin
      span_q <= span_q + SW'(`WDT_CNT_ONE);
    end
  end

  // ************************************************************
  // further checks
  // ************************************************************
  sequence psave_sleep_s;
    ps_enter && !I_EVT.power_save_idle && !I_FLAG_CLR;
  endsequence

  sequence psave_idle_s;
    ps_enter && I_EVT.power_save_idle && !I_FLAG_CLR;
  endsequence

  sequence always_last_s;
    I_CFG.enable_cfg == `WDT_EN_ALWAYS && pre_q == PRE_LAST && post_q == POST_LAST;
  endsequence

  sequence counters_zero_s;
    pre_q == '0 && post_q == '0;
  endsequence

  wake_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    ps_exit
    |=> counters_zero_s)
    else $error("leaving power save did not clear");

  run_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    clr_run
    |=> counters_zero_s)
    else $error("clear instruction did not clear");

  devrst_restart_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    rst_q
    |=> counters_zero_s)
    else $error("reset request did not restart");

  hw_sleep_count_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CFG.enable_cfg == `WDT_EN_ALWAYS && !in_run && !restart)
    |=> (pre_q != $past(pre_q)))
    else $error("stopped in power save under 11");

  always_timeout_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    always_last_s
    |=> (O_WDT_RESET || O_WDT_WAKE))
    else $error("always-on period ended silently");

  soft_count_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CFG.enable_cfg == `WDT_EN_SOFT && soft_en_q && !restart)
    |=> (pre_q != $past(pre_q)))
    else $error("soft enable did not run");

  idle_count_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CFG.enable_cfg == `WDT_EN_RUNIDLE && in_idle && !restart)
    |=> (pre_q != $past(pre_q)))
    else $error("stopped in idle under 01");

  runidle_soft_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CFG.enable_cfg == `WDT_EN_RUNIDLE && in_run && !soft_en_q && !restart)
    |=> (pre_q != $past(pre_q)))
    else $error("soft enable gated 01 mode");

  flag_set_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    any_timeout
    |=> flag_q)
    else $error("timeout flag not set");

  win_open_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (active && win_mode && in_window)
    |=> O_WINDOW_OPEN)
    else $error("window not shown open");

  wake_excl_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    O_WDT_WAKE
    |-> !O_WDT_RESET)
    else $error("wake and reset together");

  sleep_enter_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    psave_sleep_s
    |=> (in_sleep && O_SLEEP_STATUS))
    else $error("sleep entry not taken");

  idle_enter_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    psave_idle_s
    |=> (in_idle && O_IDLE_STATUS))
    else $error("idle entry not taken");

  // only software or a new power-save entry may drop the status bits
  status_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    ((O_SLEEP_STATUS || O_IDLE_STATUS) && !I_FLAG_CLR && !ps_enter)
    |=> (O_SLEEP_STATUS || O_IDLE_STATUS))
    else $error("status bit dropped by hardware");

  run_span_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    in_run
    |-> (span_q <= SPAN_LAST))
    else $error("run period overran");

endmodule : wdt_core

// ### hdl/wdt_map.svh
// constants for the windowed watchdog: config encodings and timing counts
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_EN_OFF      2'b00
`define WDT_EN_RUNIDLE  2'b01
`define WDT_EN_SOFT     2'b10
`define WDT_EN_ALWAYS   2'b11
`define WDT_PRE_DIV     128
`define WDT_POST_DIV    512
`define WDT_WIN_DIV     4
`define WDT_CNT_ONE     16'h0001
`endif

// ### hdl/wdt_pkg.sv
// types shared by the windowed watchdog
package wdt_pkg;
  typedef enum logic [2:0] {
    WDT_RUN   = 3'b001,
    WDT_SLEEP = 3'b010,
    WDT_IDLE  = 3'b100
  } wdt_mode_e;
  typedef struct packed {
    logic [1:0] enable_cfg;
    logic       window_mode_disable;
  } wdt_cfg_s;
  typedef struct packed {
    logic watchdog_clear_instr;
    logic power_save_instr;
    logic power_save_idle;
    logic osc_switch_done;
    logic wake_event;
  } wdt_evt_s;
endpackage : wdt_pkg

// ### tb/wdt_core_tb.sv
// self-checking bench for the windowed watchdog core
`timescale 1ns/1ps
module wdt_core_tb;
  import wdt_pkg::*;
  // ****************************************
  // stimulus and observation
  // ****************************************
  localparam wdt_evt_s E_CLR = 5'h10;
  localparam wdt_evt_s E_SLP = 5'h08;
  localparam wdt_evt_s E_IDL = 5'h0c;
  localparam wdt_evt_s E_OSC = 5'h02;
  localparam wdt_evt_s E_WAK = 5'h01;
  logic       clk;
  logic       rst_n;
  wdt_cfg_s   cfg;
  wdt_evt_s   evt;
  logic       sw_wr;
  logic       sw_val;
  logic       flg_clr;
  logic       soft_en, flag, wdt_rst, wake, slp, idl, win;
  logic [7:0] nr;
  logic [7:0] nw;
  int         samples_checked = 0;
  int         miscompares = 0;
  // short counts keep one period at 16 cycles
  wdt_core #(.PRE_DIV(2), .POST_DIV(8)) u_dut (
    .I_CLK_SYS(clk), .I_NRST(rst_n), .I_CFG(cfg), .I_EVT(evt),
    .I_SOFT_EN_WR(sw_wr), .I_SOFT_EN_VAL(sw_val), .I_FLAG_CLR(flg_clr),
    .O_SOFT_WATCHDOG_ENABLE(soft_en), .O_WATCHDOG_TIMEOUT_FLAG(flag),
    .O_WDT_RESET(wdt_rst), .O_WDT_WAKE(wake), .O_SLEEP_STATUS(slp),
    .O_IDLE_STATUS(idl), .O_WINDOW_OPEN(win));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // config only changes under reset, as the core expects it static
  task automatic rst(input logic [1:0] en, input logic wd);
    @(posedge clk);
    rst_n <= 1'b0;
    cfg <= '{en, wd};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
  endtask : rst
  task automatic poke(input logic w, input logic v, input logic f);
    @(posedge clk);
    {sw_wr, sw_val, flg_clr} <= {w, v, f};
    @(posedge clk);
    {sw_wr, sw_val, flg_clr} <= 3'h0;
    #1;
  endtask : poke
  // counts reset and wake pulses; pulses p every k cycles, never on the last
  task automatic watch(input int n, input int k, input wdt_evt_s p);
    nr = '0;
    nw = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      evt <= (k > 0 && i % k == k - 1 && i < n - 1) ? p : '0;
      #1;
      nr = nr + 8'(wdt_rst);
      nw = nw + 8'(wake);
    end
  endtask : watch
  task automatic s_timeout();
    rst(2'b11, 1'b1);
    chk("soft_en", soft_en, 8'h00);
    watch(14, 0, '0);
    chk("early_rst", nr, 8'h00);
    watch(8, 0, '0);
    chk("rst", nr, 8'h01);
    watch(10, 0, '0);
    chk("flag", flag, 8'h01);
    poke(1'b0, 1'b0, 1'b1);
    chk("flag_clr", flag, 8'h00);
  endtask : s_timeout
  task automatic s_clears();
    rst(2'b11, 1'b1);
    watch(60, 10, E_CLR);
    chk("clr_rst", nr, 8'h00);
    watch(60, 5, E_OSC);
    chk("osc_rst", nr, 8'h00);
    watch(10, 0, '0);
    rst(2'b11, 1'b1);
    watch(14, 0, '0);
    chk("devrst_rst", nr, 8'h00);
  endtask : s_clears
  task automatic s_window();
    int t;
    rst(2'b11, 1'b0);
    watch(8, 5, E_CLR);
    chk("early_clr", nr, 8'h01);
    chk("early_flag", flag, 8'h01);
    for (t = 0; t < 20 && win !== 1'b1; t++) begin
      @(posedge clk);
      #1;
    end
    if (t == 20) begin
      chk("win_open", win, 8'h01);
      final_report();
    end
    watch(2, 1, E_CLR);
    watch(12, 0, '0);
    chk("win_clr", nr, 8'h00);
  endtask : s_window
  task automatic s_sleep();
    for (int m = 0; m < 2; m++) begin
      rst(2'b11, 1'b1);
      watch(10, 0, '0);
      watch(2, 1, m ? E_IDL : E_SLP);
      watch(14, 0, '0);
      chk("ps_wake", nw, 8'h00);
      watch(8, 0, '0);
      chk("wake", nw, 8'h01);
      chk("wake_rst", nr, 8'h00);
      chk("status", {slp, idl}, m ? 8'h01 : 8'h02);
      chk("wake_flag", flag, 8'h01);
      poke(1'b0, 1'b0, 1'b1);
      chk("status_clr", {slp, idl}, 8'h00);
    end
  endtask : s_sleep
  task automatic s_runidle();
    rst(2'b01, 1'b1);
    poke(1'b1, 1'b1, 1'b0);
    chk("soft_store", soft_en, 8'h01);
    watch(2, 1, E_SLP);
    watch(40, 0, '0);
    chk("slp_stop", nr + nw, 8'h00);
    watch(2, 1, E_WAK);
    watch(14, 0, '0);
    chk("exit_rst", nr, 8'h00);
    watch(8, 0, '0);
    chk("run_rst", nr, 8'h01);
  endtask : s_runidle
  task automatic s_soft();
    rst(2'b10, 1'b1);
    watch(40, 0, '0);
    chk("soft_off", nr, 8'h00);
    poke(1'b1, 1'b1, 1'b0);
    chk("soft_en", soft_en, 8'h01);
    watch(22, 0, '0);
    chk("soft_rst", nr, 8'h01);
    rst(2'b10, 1'b1);
    chk("soft_en_rst", soft_en, 8'h00);
    rst(2'b00, 1'b1);
    poke(1'b1, 1'b1, 1'b0);
    watch(40, 0, '0);
    chk("off_rst", nr + nw, 8'h00);
  endtask : s_soft
  initial begin
    rst_n = 1'b0;
    cfg = '0;
    evt = '0;
    {sw_wr, sw_val, flg_clr} = 3'h0;
    s_timeout();
    s_clears();
    s_window();
    s_sleep();
    s_runidle();
    s_soft();
    final_report();
  end
endmodule : wdt_core_tb
